// ### rtl/flow_defs.vh
// constants for the program flow and branch unit: opcodes, condition codes,
// target forms, register offsets and reset values.
// assumes an included-once use from rtl/ and testbench/ sources.
`ifndef FLOW_DEFS_VH
`define FLOW_DEFS_VH

// operation classes delivered by the decoder
`define OP_NONE 3'h0
`define OP_JUMP 3'h1
`define OP_CALL 3'h2
`define OP_RET 3'h3
`define OP_RETI 3'h4
`define OP_DJNZ 3'h5

// condition tests
`define COND_ALWAYS 3'h0
`define COND_C 3'h1
`define COND_NC 3'h2
`define COND_Z 3'h3
`define COND_NZ 3'h4
`define COND_S 3'h5
`define COND_E 3'h6
`define COND_NE 3'h7

// branch target forms
`define TGT_REL8 3'h0
`define TGT_IMM8 3'h1
`define TGT_IMM16 3'h2
`define TGT_REG16 3'h3
`define TGT_REG8 3'h4

// register port offsets
`define ADDR_PROGRAM_COUNTER 3'h0
`define ADDR_HIGH_BYTE_PREFIX 3'h1
`define ADDR_LOOP_COUNT_0 3'h2
`define ADDR_LOOP_COUNT_1 3'h3
`define ADDR_STACK_POINTER 3'h4
`define ADDR_FLOW_STATUS 3'h5

// status register fields
`define STAT_ISR_ACTIVE 0
`define STAT_BAD_FORM 1

// reset values and return stack size
`define RESET_PC 16'h0000
`define RESET_PREFIX 8'h00
`define RESET_LOOP_COUNT 16'h0000
`define RESET_SP 4'hF
`define STACK_DEPTH 16
`define SP_WIDTH 4

`endif

// ### rtl/return_stack.v
// hardware return stack: 16 entries of 16 bits with an up-counting pointer.
// assumes push and pop are never requested in the same cycle.
`default_nettype none

`include "flow_defs.vh"

module return_stack (
  input wire ref_clk,
  input wire rst,
  input wire push,
  input wire pop,
  input wire [15:0] push_data,
  output wire [15:0] top_data,
  output reg [`SP_WIDTH-1:0] stack_pointer
);

  reg [15:0] mem [0:`STACK_DEPTH-1];
  wire [`SP_WIDTH-1:0] sp_inc;
  wire [`SP_WIDTH-1:0] sp_dec;

  assign sp_inc = stack_pointer + 4'h1;
  assign sp_dec = stack_pointer - 4'h1;
  // pop reads the current top before the pointer moves down
  assign top_data = mem[stack_pointer];

  // pointer wraps silently; overflow is software's problem, as on the core
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stack_pointer <= `RESET_SP;
    end else if (push) begin
      stack_pointer <= sp_inc;
    end else if (pop) begin
      stack_pointer <= sp_dec;
    end
  end

  // entries are not reset: only the pointer has a defined value
  always @(posedge ref_clk) begin
    if (push) begin
      mem[sp_inc] <= push_data; // store at the new top
    end
  end

endmodule

`default_nettype wire

// ### rtl/program_flow_branch_unit.v
// program flow unit: jumps, calls, returns and counted loops for the core.
// assumes a decoder presents one instruction per cycle with instr_valid, and
// flags from the ALU on the same clock; fetch follows fetch_addr.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

`include "flow_defs.vh"

module program_flow_branch_unit (
  input wire ref_clk,
  input wire rst,
  // decoded instruction
  input wire instr_valid,
  input wire [2:0] op,
  input wire [2:0] cond,
  input wire [2:0] target_form,
  input wire [15:0] imm_value,
  input wire [15:0] src_reg_value,
  input wire loop_select,
  // status flags
  input wire flag_carry,
  input wire flag_equals,
  input wire flag_zero,
  input wire flag_sign,
  // interrupt entry from the interrupt controller
  input wire isr_enter,
  // register port
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  // fetch side and status outputs
  output reg [15:0] fetch_addr,
  output reg discard,
  output reg isr_active_flag,
  output reg bad_form
);

  reg [15:0] program_counter_reg;
  reg [15:0] program_counter_next;
  reg [7:0] high_byte_prefix_reg;
  reg bad_form_sticky_reg;

  reg taken;
  reg do_push;
  reg do_pop;
  reg illegal;
  reg [15:0] loop_count_dec;
  reg [15:0] branch_target;

  wire [15:0] top_data;
  wire [`SP_WIDTH-1:0] stack_pointer;
  wire [15:0] seq_addr;
  wire wr_prefix;
  wire wr_status;
  wire [15:0] sel_loop_count;
  wire [15:0] loop_count_0;
  wire [15:0] loop_count_1;
  wire [31:0] loop_count_all;
  wire [1:0] lc_load;
  wire [1:0] lc_step;
  genvar n;

  // register write decode, shared by every writable register
  function wr_hit;
    input wr;
    input [2:0] addr;
    input [2:0] sel;
    begin
      wr_hit = wr && (addr == sel);
    end
  endfunction

  // instruction class decode, shared by the loop counters and the service flag
  function op_hit;
    input valid;
    input [2:0] code;
    input [2:0] want;
    begin
      op_hit = valid && (code == want);
    end
  endfunction

  // fetch_addr mirrors the program counter so fetch needs no adder of its own
  assign seq_addr = program_counter_reg + 16'h0001;
  assign wr_prefix = wr_hit(reg_write, reg_addr, `ADDR_HIGH_BYTE_PREFIX);
  assign wr_status = wr_hit(reg_write, reg_addr, `ADDR_FLOW_STATUS);
  assign lc_load[0] = wr_hit(reg_write, reg_addr, `ADDR_LOOP_COUNT_0);
  assign lc_load[1] = wr_hit(reg_write, reg_addr, `ADDR_LOOP_COUNT_1);
  assign lc_step[0] = op_hit(instr_valid, op, `OP_DJNZ) && !loop_select;
  assign lc_step[1] = op_hit(instr_valid, op, `OP_DJNZ) && loop_select;
  assign loop_count_0 = loop_count_all[15:0];
  assign loop_count_1 = loop_count_all[31:16];
  assign sel_loop_count = loop_select ? loop_count_1 : loop_count_0;

  // condition test shared by jumps, returns and interrupt returns
  function cond_true;
    input [2:0] c;
    input fc;
    input fe;
    input fz;
    input fs;
    begin
      case (c)
        `COND_ALWAYS: cond_true = 1'b1;
        `COND_C: cond_true = fc;
        `COND_NC: cond_true = ~fc;
        `COND_Z: cond_true = fz;
        `COND_NZ: cond_true = ~fz;
        `COND_S: cond_true = fs;
        `COND_E: cond_true = fe;
        `COND_NE: cond_true = ~fe;
        default: cond_true = 1'b0;
      endcase
    end
  endfunction

  // sign-extends a byte offset to a word for relative targets
  function [15:0] sext8;
    input [7:0] b;
    begin
      sext8 = {{8{b[7]}}, b};
    end
  endfunction

  // target resolution shared by jump, call and loop
  function [15:0] resolve_target;
    input [2:0] form;
    input [15:0] pc;
    input [15:0] imm;
    input [15:0] regv;
    input [7:0] prefix;
    begin
      case (form)
        `TGT_REL8: resolve_target = pc + sext8(imm[7:0]);
        `TGT_IMM8: resolve_target = {prefix, imm[7:0]};
        `TGT_IMM16: resolve_target = imm;
        `TGT_REG16: resolve_target = regv;
        `TGT_REG8: resolve_target = {prefix, regv[7:0]};
        default: resolve_target = pc;
      endcase
    end
  endfunction

  // equals tests with a register target are refused and act as no-ops
  function form_illegal;
    input [2:0] c;
    input [2:0] form;
    begin
      form_illegal = ((c == `COND_E) || (c == `COND_NE)) &&
                     ((form == `TGT_REG16) || (form == `TGT_REG8));
    end
  endfunction

  // a taken transfer picks the resolved target; everything else steps by one
  always @* begin
    taken = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    illegal = 1'b0;
    loop_count_dec = sel_loop_count - 16'h0001;
    branch_target = resolve_target(target_form, program_counter_reg, imm_value,
                                   src_reg_value, high_byte_prefix_reg);
    program_counter_next = seq_addr;
    if (instr_valid) begin
      case (op)
        `OP_JUMP: begin
          illegal = form_illegal(cond, target_form);
          taken = ~illegal &&
                  cond_true(cond, flag_carry, flag_equals, flag_zero, flag_sign);
        end
        `OP_CALL: begin
          taken = 1'b1;
          do_push = 1'b1; // next address goes on the stack first
        end
        `OP_RET, `OP_RETI: begin
          // a false condition neither pops nor moves the pointer
          taken = cond_true(cond, flag_carry, flag_equals, flag_zero, flag_sign);
          do_pop = taken;
          branch_target = top_data;
        end
        `OP_DJNZ: begin
          taken = (loop_count_dec != 16'h0000);
        end
        default: begin
          taken = 1'b0;
        end
      endcase
      if (taken) begin
        program_counter_next = branch_target;
      end
    end
  end

  // the counter only moves when an instruction executes; idle cycles hold it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      program_counter_reg <= `RESET_PC;
      fetch_addr <= `RESET_PC;
    end else if (instr_valid) begin
      program_counter_reg <= program_counter_next;
      fetch_addr <= program_counter_next;
    end
  end

  // the prefetched word behind a taken transfer must not execute
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      discard <= 1'b0;
    end else begin
      discard <= instr_valid && taken;
    end
  end

  // a refused form is flagged for one cycle beside the sticky status bit
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bad_form <= 1'b0;
    end else begin
      bad_form <= illegal;
    end
  end

  // a prefix write arms one instruction; the next one consumes it
  // a write in the same cycle as an instruction wins, arming the one after
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_byte_prefix_reg <= `RESET_PREFIX;
    end else if (wr_prefix) begin
      high_byte_prefix_reg <= reg_wdata[7:0];
    end else if (instr_valid) begin
      high_byte_prefix_reg <= `RESET_PREFIX;
    end
  end

  // software loads win over a simultaneous decrement
  // each counter steps only when its own loop instruction executes
  generate
    for (n = 0; n < 2; n = n + 1) begin : loop_counter
      reg [15:0] count_reg;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          count_reg <= `RESET_LOOP_COUNT;
        end else if (lc_load[n]) begin
          count_reg <= reg_wdata;
        end else if (lc_step[n]) begin
          count_reg <= loop_count_dec;
        end
      end
      assign loop_count_all[16*n+15:16*n] = count_reg;
    end
  endgenerate

  // entry sets the flag and wins over a return in the same cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      isr_active_flag <= 1'b0;
    end else if (isr_enter) begin
      isr_active_flag <= 1'b1;
    end else if (op_hit(instr_valid, op, `OP_RETI) && taken) begin
      isr_active_flag <= 1'b0;
    end
  end

  // refused form is recorded until software writes a one to clear it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bad_form_sticky_reg <= 1'b0;
    end else if (illegal) begin
      bad_form_sticky_reg <= 1'b1;
    end else if (wr_status && reg_wdata[`STAT_BAD_FORM]) begin
      bad_form_sticky_reg <= 1'b0;
    end
  end

  // read multiplexer; unmapped offsets read as zero
  function [15:0] read_word;
    input [2:0] addr;
    input [15:0] pc_plus_one;
    input [7:0] prefix;
    input [15:0] count_0;
    input [15:0] count_1;
    input [`SP_WIDTH-1:0] sp;
    input bad;
    input isr;
    begin
      case (addr)
        `ADDR_PROGRAM_COUNTER: read_word = pc_plus_one;
        `ADDR_HIGH_BYTE_PREFIX: read_word = {8'h00, prefix};
        `ADDR_LOOP_COUNT_0: read_word = count_0;
        `ADDR_LOOP_COUNT_1: read_word = count_1;
        `ADDR_STACK_POINTER: read_word = {12'h000, sp};
        `ADDR_FLOW_STATUS: read_word = {14'h0, bad, isr};
        default: read_word = 16'h0000;
      endcase
    end
  endfunction

  // read data stand for one cycle only, so a stale word never looks fresh
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= read_word(reg_addr, seq_addr, high_byte_prefix_reg, loop_count_0,
                             loop_count_1, stack_pointer, bad_form_sticky_reg,
                             isr_active_flag);
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  return_stack stack_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(do_push),
    .pop(do_pop),
    .push_data(seq_addr),
    .top_data(top_data),
    .stack_pointer(stack_pointer)
  );

endmodule

`default_nettype wire

// ### testbench/flow_monitor.sv
// checker for the program flow unit ports
// assumes one clock, ref_clk, and asynchronous active-high rst
`default_nettype none
`include "flow_defs.vh"
module flow_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [2:0] op,
  input wire logic [2:0] cond,
  input wire logic [2:0] target_form,
  input wire logic [15:0] imm_value,
  input wire logic [15:0] src_reg_value,
  input wire logic flag_carry,
  input wire logic isr_enter,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] fetch_addr,
  input wire logic discard,
  input wire logic isr_active_flag,
  input wire logic bad_form
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic jv = instr_valid && op == `OP_JUMP;
  wire logic ja = jv && cond == `COND_ALWAYS;
  logic [7:0] pfx_h;
  always_ff @(posedge ref_clk)
    if (reg_write && reg_addr == `ADDR_HIGH_BYTE_PREFIX) pfx_h <= reg_wdata[7:0];
  sequence s_pfx_set; reg_write && reg_addr == `ADDR_HIGH_BYTE_PREFIX; endsequence
  sequence s_reg8_jump; ja && target_form == `TGT_REG8 && !reg_write; endsequence
  property p_rel8;
    ja && target_form == `TGT_REL8 |=> fetch_addr ==
      $past(fetch_addr) + {{8{$past(imm_value[7])}}, $past(imm_value[7:0])};
  endproperty
  a_rel8: assert property (p_rel8) else $error("relative jump target wrong");
  property p_abs; ja && target_form == `TGT_IMM16 |=> fetch_addr == $past(imm_value); endproperty
  a_abs: assert property (p_abs) else $error("immediate jump target wrong");
  property p_reg16;
    ja && target_form == `TGT_REG16 |=> fetch_addr == $past(src_reg_value);
  endproperty
  a_reg16: assert property (p_reg16) else $error("register jump target wrong");
  // the prefix must survive the idle cycle and be spent by the jump
  property p_reg8;
    s_pfx_set ##1 !instr_valid ##1 s_reg8_jump |=>
      fetch_addr == {pfx_h, $past(src_reg_value[7:0])};
  endproperty
  a_reg8: assert property (p_reg8) else $error("byte register target wrong");
  property p_nc;
    jv && cond == `COND_C && !flag_carry |=>
      fetch_addr == $past(fetch_addr) + 16'h0001 && !discard;
  endproperty
  a_nc: assert property (p_nc) else $error("untaken jump moved");
  property p_eq_reg;
    jv && cond inside {`COND_E, `COND_NE} && target_form inside {`TGT_REG16, `TGT_REG8}
      |=> bad_form && !discard;
  endproperty
  a_eq_reg: assert property (p_eq_reg) else $error("equals register jump taken");
  property p_flush; instr_valid && op == `OP_CALL |=> discard ##1 !discard; endproperty
  a_flush: assert property (p_flush) else $error("call did not flush once");
  property p_reti;
    instr_valid && op == `OP_RETI && cond == `COND_ALWAYS && !isr_enter |=> !isr_active_flag;
  endproperty
  a_reti: assert property (p_reti) else $error("service flag kept after return");
  property p_pc_read;
    reg_read && reg_addr == `ADDR_PROGRAM_COUNTER |=> reg_rdata == $past(fetch_addr) + 16'h0001;
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("pc read wrong");
endmodule
bind program_flow_branch_unit flow_monitor mon (.*);
`default_nettype wire

// ### testbench/program_store.sv
// program memory model: the word at the fetch address feeds the immediate
// assumes the bench stores each word before its fetch is used
`default_nettype none
module program_store (
  input wire logic [15:0] fetch_addr,
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words [0:255];
  // unwritten words read as the inverted address so no stale value leaks
  initial for (int i = 0; i < 256; i++) words[i] = ~16'(i);
  assign word = words[fetch_addr[7:0]];
endmodule
`default_nettype wire

// ### testbench/program_flow_branch_unit_tb.sv
// bench for the program flow unit: register and instruction tasks
// assumes flow_defs.vh on the include path and program_store as memory
`default_nettype none
`include "flow_defs.vh"
module program_flow_branch_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, instr_valid = 0, isr_enter = 0, reg_write = 0, reg_read = 0;
  logic [2:0] op = 0, cond = 0, target_form = 0, reg_addr = 0;
  logic [15:0] src_reg_value = 0, reg_wdata = 0, imm_value, reg_rdata, fetch_addr;
  logic [15:0] pcm = 0, tg;
  logic [4:0] fl = 0;
  logic [3:0] ff;
  logic discard, isr_active_flag, bad_form;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  program_store mem (.fetch_addr(fetch_addr), .word(imm_value));
  program_flow_branch_unit dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .op(op), .cond(cond), .target_form(target_form), .imm_value(imm_value),
    .src_reg_value(src_reg_value), .loop_select(fl[4]), .flag_carry(fl[0]),
    .flag_equals(fl[1]), .flag_zero(fl[2]), .flag_sign(fl[3]), .isr_enter(isr_enter),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .fetch_addr(fetch_addr), .discard(discard),
    .isr_active_flag(isr_active_flag), .bad_form(bad_form));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  // one instruction; a flush is expected whenever the next address is not pc+1
  task automatic ex(input logic [2:0] o, c, f, input logic [15:0] im, rv,
                    input logic [4:0] fg, input logic [15:0] nx);
    mem.words[pcm[7:0]] = im;
    @(posedge ref_clk);
    op <= o;
    cond <= c;
    target_form <= f;
    src_reg_value <= rv;
    fl <= fg;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk("fetch_addr", fetch_addr, nx);
    chk("discard", {15'h0, discard}, {15'h0, nx !== pcm + 16'h1});
    pcm = nx;
  endtask
  function automatic logic tk(input logic [2:0] c, input logic [3:0] f);
    case (c)
      `COND_C: return f[0];
      `COND_NC: return !f[0];
      `COND_Z: return f[2];
      `COND_NZ: return !f[2];
      `COND_S: return f[3];
      `COND_E: return f[1];
      `COND_NE: return !f[1];
      default: return 1'b1;
    endcase
  endfunction
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`ADDR_PROGRAM_COUNTER, 16'h0001, "pc");
    rd(`ADDR_STACK_POINTER, 16'h000F, "sp");
    rd(3'h7, 16'h0000, "unmapped");
    ex(`OP_JUMP, 0, `TGT_IMM16, 16'h0200, 0, 0, 16'h0200);
    ex(`OP_JUMP, 0, `TGT_REL8, 16'h0080, 0, 0, 16'h0180);
    ex(`OP_JUMP, 0, `TGT_REL8, 16'h007F, 0, 0, 16'h01FF);
    ex(`OP_JUMP, 0, `TGT_REG16, 0, 16'h1234, 0, 16'h1234);
    wr(`ADDR_HIGH_BYTE_PREFIX, 16'h0056);
    ex(`OP_JUMP, 0, `TGT_REG8, 0, 16'h77AB, 0, 16'h56AB);
    ex(`OP_JUMP, 0, `TGT_REG8, 0, 16'h00CD, 0, 16'h00CD);
    wr(`ADDR_HIGH_BYTE_PREFIX, 16'h0012);
    ex(`OP_JUMP, 0, `TGT_IMM8, 16'hFF34, 0, 0, 16'h1234);
    for (int c = 1; c < 8; c++)
      for (int f = 0; f < 16; f++) begin
        tg = {4'h4, c[3:0], f[3:0], 4'h0};
        ex(`OP_JUMP, c[2:0], `TGT_IMM16, tg, 0, {1'b0, f[3:0]},
           tk(c[2:0], f[3:0]) ? tg : pcm + 16'h1);
      end
    ex(`OP_JUMP, `COND_E, `TGT_REG16, 0, 16'h0800, 5'h02, pcm + 16'h1);
    rd(`ADDR_FLOW_STATUS, 16'h0002, "status");
    wr(`ADDR_FLOW_STATUS, 16'h0002);
    rd(`ADDR_FLOW_STATUS, 16'h0000, "status");
    for (int c = 1; c < 6; c++) begin
      tg = pcm + 16'h1;
      ff = tk(c[2:0], 4'h0) ? 4'hF : 4'h0;
      ex(`OP_CALL, 0, `TGT_IMM16, 16'h0600 + 16'(c * 16), 0, 0, 16'h0600 + 16'(c * 16));
      rd(`ADDR_STACK_POINTER, 16'h0000, "sp");
      ex(`OP_RET, c[2:0], 0, 0, 0, {1'b0, ff}, pcm + 16'h1);
      rd(`ADDR_STACK_POINTER, 16'h0000, "sp");
      ex(`OP_RET, c[2:0], 0, 0, 0, {1'b0, ~ff}, tg);
      rd(`ADDR_STACK_POINTER, 16'h000F, "sp");
    end
    @(posedge ref_clk);
    isr_enter <= 1'b1;
    @(posedge ref_clk);
    isr_enter <= 1'b0;
    rd(`ADDR_FLOW_STATUS, 16'h0001, "status");
    tg = pcm + 16'h1;
    ex(`OP_CALL, 0, `TGT_IMM16, 16'h0700, 0, 0, 16'h0700);
    ex(`OP_RETI, 0, 0, 0, 0, 0, tg);
    rd(`ADDR_FLOW_STATUS, 16'h0000, "status");
    wr(`ADDR_LOOP_COUNT_1, 16'h0003);
    for (int i = 2; i >= 0; i--)
      ex(`OP_DJNZ, 0, `TGT_REL8, 16'h00FE, 0, 5'h10, i ? pcm - 16'h2 : pcm + 16'h1);
    rd(`ADDR_LOOP_COUNT_1, 16'h0000, "loop_count_1");
    wr(`ADDR_LOOP_COUNT_0, 16'h0003);
    ex(`OP_DJNZ, 0, `TGT_REG16, 0, 16'h0900, 0, 16'h0900);
    wr(`ADDR_HIGH_BYTE_PREFIX, 16'h0009);
    ex(`OP_DJNZ, 0, `TGT_IMM8, 16'h0055, 0, 0, 16'h0955);
    rd(`ADDR_HIGH_BYTE_PREFIX, 16'h0000, "prefix");
    ex(`OP_DJNZ, 0, `TGT_REL8, 16'h00F0, 0, 0, pcm + 16'h1);
    rd(`ADDR_LOOP_COUNT_0, 16'h0000, "loop_count_0");
    complete_run();
  end
endmodule
`default_nettype wire
